// [ssr_consts.vh]
// constants of the synchronous master receiver
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSR_OFS_CTRL 8'h00
`define SSR_OFS_BAUD 8'h04
`define SSR_OFS_STAT 8'h08
`define SSR_OFS_DATA 8'h0c
`define SSR_OFS_IRQC 8'h10
`define SSR_OFS_ISTS 8'h14
`define SSR_OFS_IMSK 8'h18
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SSR_B_SERIAL_PORT_ENABLE   0
`define SSR_B_SYNC   1
`define SSR_B_CLOCK_SOURCE_MASTER_SELECT   2
`define SSR_B_SINGLE_RECEIVE_ENABLE   3
`define SSR_B_CONTINUOUS_RECEIVE_ENABLE   4
`define SSR_B_RX9    5
`define SSR_B_HSPD   6
`define SSR_B_WIDE   7
`define SSR_CTRL_RST 8'h00
// ----------------------------------------------------------------
// status, irq control and event fields
// ----------------------------------------------------------------
`define SSR_B_NINTH  0
`define SSR_B_OVR    1
`define SSR_B_RXIF   2
`define SSR_B_RXIE   0
`define SSR_B_PERIPHERAL_IRQ_GATE   1
`define SSR_B_GIE    2
`define SSR_B_EV_CH  0
`define SSR_B_EV_OV  1
// ----------------------------------------------------------------
// widths, counts and bus answers
// ----------------------------------------------------------------
`define SSR_BITS8    4'd8
`define SSR_BITS9    4'd9
`define SSR_FIFO_N   2'd2
`define SSR_PRE_HS   5'd1
`define SSR_PRE_WD   5'd7
`define SSR_PRE_LG   5'd31
`define SSR_RESP_OK  2'b00
`define SSR_RESP_ERR 2'b10
`endif

// [ssr_baud.v]
// baud generator: half bit clock enable pulses
module ssr_baud
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        run,
  input  wire        wide,
  input  wire        high_speed,
  input  wire [7:0]  div_low,
  input  wire [7:0]  div_high,
  output reg         tick
);
`include "ssr_consts.vh"

  reg  [4:0]  pre;
  reg  [15:0] cnt;
  wire [4:0]  pre_lim;
  wire [15:0] cnt_lim;

  // divisor shaped by speed and width selects
  assign pre_lim = high_speed ? `SSR_PRE_HS : (wide ? `SSR_PRE_WD : `SSR_PRE_LG);
  assign cnt_lim = wide ? {div_high, div_low} : {8'h00, div_low};

  always @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      pre  <= 5'h00;
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (pre >= pre_lim)
      begin
        pre <= 5'h00;
        if (cnt >= cnt_lim)
        begin
          cnt  <= 16'h0000;
          tick <= 1'b1;
        end
        else
          cnt <= cnt + 16'h0001;
      end
      else
        pre <= pre + 5'h01;
    end
  end
endmodule

// [ssr_rx.v]
// synchronous master receiver with axi4-lite registers
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`include "ssr_consts.vh"

// Function
// - clock rate from divisor pair, shaped by high-speed and wide selects
// - master operation only with sync, port enable and clock source set
// - receive interrupt needs peripheral and global enables, plus receive enable or the imsk character event bit
// - nine-bit select gives nine data bits per character
// - single enable starts one character, continuous enable keeps receiving
// - receive flag set once a whole character arrived
// - interrupt on completion with receive enable or character event unmasked in imsk, else flag only
// - status shows ninth bit and errors of received character
// - data register read returns low eight data bits
// - overrun cleared by continuous enable clear or port disable
// - two-deep fifo; third character sets overrun, keeps data, stops
// - single-mode overrun cleared by reading data register
module ssr_rx
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        data_pin_in,
  output reg         clock_pin_out,
  output reg         clock_pin_oe,
  output reg         irq
);

  localparam ST_IDLE = 2'd0;
  localparam ST_LOW  = 2'd1;
  localparam ST_HIGH = 2'd2;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl;
  reg  [7:0]  baud_divisor_low;
  reg  [7:0]  baud_divisor_high;
  reg  [2:0]  irq_control_reg;
  reg  [1:0]  ists;
  reg  [1:0]  imsk;
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         data_meta;
  reg         data_sync;
  reg  [1:0]  state;
  reg  [8:0]  shreg;
  reg  [3:0]  bit_cnt;
  reg  [8:0]  fifo_mem [0:1];
  reg         rd_idx;
  reg  [1:0]  fifo_cnt;
  reg         overrun_error_flag;
  reg         ovr_single;
  reg         continuous_receive_enable_prev;
  wire        tick;
  wire        serial_port_enable;
  wire        continuous_receive_enable;
  wire        single_receive_enable;
  wire        master_ok;
  wire        receive_irq_flag;
  wire        wr_fire;
  wire        rd_fire;
  wire        data_pop;
  wire        ists_read;
  wire [8:0]  next_sh;
  wire [3:0]  nbits;
  wire        last_bit;
  wire        char_done;
  wire        push;
  wire        ovr_set;
  wire        ovr_clr;
  wire [8:0]  char9;
  wire [15:0] baud_merged;

  assign serial_port_enable        = ctrl[`SSR_B_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable = ctrl[`SSR_B_CONTINUOUS_RECEIVE_ENABLE];
  assign single_receive_enable     = ctrl[`SSR_B_SINGLE_RECEIVE_ENABLE];
  // master only with sync, enable and clock source set
  assign master_ok = ctrl[`SSR_B_SERIAL_PORT_ENABLE] & ctrl[`SSR_B_SYNC] & ctrl[`SSR_B_CLOCK_SOURCE_MASTER_SELECT];
  // flag stands while an unread character waits
  assign receive_irq_flag = (fifo_cnt != 2'd0);

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  ssr_baud u_baud
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (state != ST_IDLE),
    .wide       (ctrl[`SSR_B_WIDE]),
    .high_speed (ctrl[`SSR_B_HSPD]),
    .div_low    (baud_divisor_low),
    .div_high   (baud_divisor_high),
    .tick       (tick)
  );

  // ----------------------------------------------------------------
  // data pin synchroniser
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end
    else
    begin
      data_meta <= data_pin_in;
      data_sync <= data_meta;
    end
  end

  // ----------------------------------------------------------------
  // receive shifter and fifo
  // ----------------------------------------------------------------
  assign nbits     = ctrl[`SSR_B_RX9] ? `SSR_BITS9 : `SSR_BITS8;
  assign next_sh   = {data_sync, shreg[8:1]};
  assign last_bit  = (bit_cnt == nbits - 4'd1);
  assign char_done = (state == ST_HIGH) && tick && last_bit;
  assign char9     = ctrl[`SSR_B_RX9] ? next_sh : {1'b0, next_sh[8:1]};
  assign push      = char_done && (fifo_cnt != `SSR_FIFO_N);
  assign ovr_set   = char_done && (fifo_cnt == `SSR_FIFO_N);
  assign data_pop  = rd_fire && (s_axi_araddr == `SSR_OFS_DATA) && (fifo_cnt != 2'd0);
  assign ists_read = rd_fire && (s_axi_araddr == `SSR_OFS_ISTS);
  // overrun leaves by enable clear or single-mode data read
  assign ovr_clr   = (continuous_receive_enable_prev && !continuous_receive_enable) ||
                     (data_pop && ovr_single);

  always @(posedge aclk)
  begin
    if (!aresetn || !serial_port_enable)
    begin
      state              <= ST_IDLE;
      shreg              <= 9'h000;
      bit_cnt            <= 4'h0;
      fifo_mem[0]        <= 9'h000;
      fifo_mem[1]        <= 9'h000;
      rd_idx             <= 1'b0;
      fifo_cnt           <= 2'd0;
      overrun_error_flag <= 1'b0;
      ovr_single         <= 1'b0;
      clock_pin_out      <= 1'b0;
      clock_pin_oe       <= 1'b0;
    end
    else
    begin
      if (push)
        fifo_mem[rd_idx ^ fifo_cnt[0]] <= char9;
      if (data_pop)
        rd_idx <= ~rd_idx;
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, data_pop};
      if (ovr_set)
      begin
        overrun_error_flag <= 1'b1;
        ovr_single         <= !continuous_receive_enable;
      end
      else if (ovr_clr)
      begin
        overrun_error_flag <= 1'b0;
        ovr_single         <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          clock_pin_out <= 1'b0;
          bit_cnt       <= 4'h0;
          // start on either enable, held off by overrun
          if (master_ok && !overrun_error_flag &&
              (single_receive_enable || continuous_receive_enable))
          begin
            state        <= ST_LOW;
            clock_pin_oe <= 1'b1;
          end
          else
            clock_pin_oe <= 1'b0;
        end
        ST_LOW:
        begin
          if (!master_ok)
            state <= ST_IDLE;
          else if (tick)
          begin
            clock_pin_out <= 1'b1;
            state         <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (!master_ok)
            state <= ST_IDLE;
          else if (tick)
          begin
            // trailing edge: sample one bit per clock
            clock_pin_out <= 1'b0;
            shreg         <= next_sh;
            if (last_bit)
            begin
              bit_cnt <= 4'h0;
              if (continuous_receive_enable && !ovr_set)
                state <= ST_LOW;
              else
              begin
                state        <= ST_IDLE;
                clock_pin_oe <= 1'b0;
              end
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              state   <= ST_LOW;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
  assign baud_merged = merge16({baud_divisor_high, baud_divisor_low}, w_data[15:0],
                               w_strb[1:0]);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `SSR_RESP_OK;
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 8'h00;
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      ctrl              <= `SSR_CTRL_RST;
      baud_divisor_low  <= 8'h00;
      baud_divisor_high <= 8'h00;
      irq_control_reg   <= 3'h0;
      imsk              <= 2'h0;
      continuous_receive_enable_prev         <= 1'b0;
    end
    else
    begin
      continuous_receive_enable_prev     <= continuous_receive_enable;
      // no new address or data while a write answer is pending
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid &&
                       !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // single character done: enable drops by itself
      if (char_done && !continuous_receive_enable)
        ctrl[`SSR_B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SSR_RESP_OK;
        case (aw_addr)
          `SSR_OFS_CTRL:
          begin
            if (w_strb[0])
              ctrl <= w_data[7:0];
          end
          `SSR_OFS_BAUD:
          begin
            baud_divisor_low  <= baud_merged[7:0];
            baud_divisor_high <= baud_merged[15:8];
          end
          `SSR_OFS_IRQC:
          begin
            if (w_strb[0])
              irq_control_reg <= w_data[2:0];
          end
          `SSR_OFS_IMSK:
          begin
            if (w_strb[0])
              imsk <= w_data[1:0];
          end
          `SSR_OFS_STAT, `SSR_OFS_DATA, `SSR_OFS_ISTS:
          begin
            s_axi_bresp <= `SSR_RESP_OK;
          end
          default:
          begin
            s_axi_bresp <= `SSR_RESP_ERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SSR_RESP_OK;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `SSR_RESP_OK;
        s_axi_rdata   <= 32'h00000000;
        case (s_axi_araddr)
          `SSR_OFS_CTRL: s_axi_rdata[7:0] <= ctrl;
          `SSR_OFS_BAUD: s_axi_rdata[15:0] <= {baud_divisor_high, baud_divisor_low};
          // ninth bit of top entry and errors
          `SSR_OFS_STAT:
          begin
            s_axi_rdata[`SSR_B_NINTH] <= fifo_mem[rd_idx][8];
            s_axi_rdata[`SSR_B_OVR]   <= overrun_error_flag;
            s_axi_rdata[`SSR_B_RXIF]  <= receive_irq_flag;
          end
          `SSR_OFS_DATA: s_axi_rdata[7:0] <= fifo_mem[rd_idx][7:0];
          `SSR_OFS_IRQC: s_axi_rdata[2:0] <= irq_control_reg;
          `SSR_OFS_ISTS: s_axi_rdata[1:0] <= ists;
          `SSR_OFS_IMSK: s_axi_rdata[1:0] <= imsk;
          default:       s_axi_rresp <= `SSR_RESP_ERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ists <= 2'h0;
      irq  <= 1'b0;
    end
    else
    begin
      // set wins over the clear of a read
      ists[`SSR_B_EV_CH] <= push || (ists[`SSR_B_EV_CH] && !ists_read);
      ists[`SSR_B_EV_OV] <= ovr_set || (ists[`SSR_B_EV_OV] && !ists_read);
      // gated by global and peripheral enables
      irq <= irq_control_reg[`SSR_B_GIE] && irq_control_reg[`SSR_B_PERIPHERAL_IRQ_GATE] &&
             ((irq_control_reg[`SSR_B_RXIE] && receive_irq_flag) || (|(ists & imsk)));
    end
  end
endmodule

// [ssr_rx_checker.sv]
// concurrent checks on the receiver ports
module ssr_rx_checker
(
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        data_pin_in,
  input wire        clock_pin_out,
  input wire        clock_pin_oe,
  input wire        irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_oe_idle_low: assert property (!clock_pin_oe |-> !clock_pin_out)
    else $error("clock high while pin released");
  a_high_half_min: assert property ($rose(clock_pin_out) |=> clock_pin_out)
    else $error("clock high half too short");
  a_low_half_min: assert property ($fell(clock_pin_out) |=> !clock_pin_out)
    else $error("clock low half too short");
  a_oe_start_low: assert property ($rose(clock_pin_oe) |-> !clock_pin_out ##1 !clock_pin_out)
    else $error("reception did not open with low half");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken with read pending");
  a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  c_frame_end: cover property ($fell(clock_pin_oe));
  c_irq_rise: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind ssr_rx ssr_rx_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_pin_in,
  .clock_pin_out, .clock_pin_oe, .irq);

// [ssr_slave.sv]
// synchronous slave that sends characters
module ssr_slave
(
  input wire       clk_pin,
  input wire       clk_oe,
  input wire [8:0] word,
  input wire [3:0] nbits,
  output reg       data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] idx;
  // digital data line, no analog select to clear
  initial
  begin
    idx = 4'h0;
    data_pin = 1'b0;
  end
  // new bit on leading edge, lsb first
  always @(posedge clk_pin)
  begin
    data_pin <= word[idx];
    idx <= (idx + 4'h1 == nbits) ? 4'h0 : idx + 4'h1;
  end
  // released line shows inverse of last bit
  always @(negedge clk_oe)
  begin
    idx <= 4'h0;
    data_pin <= ~data_pin;
  end
endmodule

// [test_ssr_rx.sv]
// register level tests of the receiver
`include "ssr_consts.vh"
module test_ssr_rx;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        data_pin_in;
  logic        clock_pin_out;
  logic        clock_pin_oe;
  logic        irq;
  logic [8:0]  slave_word = 9'h0;
  logic [3:0]  slave_n = 4'h8;
  logic [1:0]  rsp;
  logic [31:0] v;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  bx [3] = '{8'h40, 8'h00, 8'h80};
  logic [15:0] bd [3] = '{16'h0003, 16'h0000, 16'h0100};
  int          bh [3] = '{8, 32, 2056};
  logic [8:0]  tw [3] = '{9'h011, 9'h022, 9'h033};
  always #5 aclk = ~aclk;
  ssr_rx DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .data_pin_in, .clock_pin_out, .clock_pin_oe, .irq);
  ssr_slave u_slave (.clk_pin(clock_pin_out), .clk_oe(clock_pin_oe), .word(slave_word),
    .nbits(slave_n), .data_pin(data_pin_in));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic td;
    ta = 1'b0;
    td = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (ta && td && s_axi_bvalid === 1'b1) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      ta = ta | (s_axi_awready === 1'b1);
      td = td | (s_axi_wready === 1'b1);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    do rd(a); while ((v & m) == 32'h0);
  endtask
  task automatic print_verdict;
    $display("counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`SSR_OFS_CTRL, 32'h0);
    rc(`SSR_OFS_STAT, 32'h0);
    chk({30'h0, irq, clock_pin_oe}, 32'h0);
    rc(8'h1c, 32'h0);
    chk(rsp, `SSR_RESP_ERR);
    wr(8'h1c, 32'h1);
    chk(rsp, `SSR_RESP_ERR);
    $display("test reset done");
    wr(`SSR_OFS_BAUD, 32'h3);
    wr(`SSR_OFS_CTRL, 32'h4b);
    repeat (100) @(posedge aclk);
    chk(clock_pin_oe, 1'b0);
    wr(`SSR_OFS_CTRL, 32'h0);
    $display("test master enable done");
    for (int i = 0; i < 3; i++)
    begin
      wr(`SSR_OFS_BAUD, {16'h0, bd[i]});
      wr(`SSR_OFS_CTRL, {24'h0, bx[i] | 8'h0f});
      do @(posedge aclk); while (clock_pin_out !== 1'b1);
      n = 0;
      while (clock_pin_out === 1'b1)
      begin
        n++;
        @(posedge aclk);
      end
      chk(n, bh[i]);
      wr(`SSR_OFS_CTRL, 32'h0);
    end
    $display("test baud done");
    wr(`SSR_OFS_BAUD, 32'h3);
    slave_word <= 9'h0a5;
    wr(`SSR_OFS_CTRL, 32'h47);
    wr(`SSR_OFS_CTRL, 32'h4f);
    poll(`SSR_OFS_STAT, 32'h4);
    chk(irq, 1'b0);
    rc(`SSR_OFS_CTRL, 32'h47);
    rc(`SSR_OFS_ISTS, 32'h1);
    rc(`SSR_OFS_ISTS, 32'h0);
    rc(`SSR_OFS_DATA, 32'ha5);
    rc(`SSR_OFS_STAT, 32'h0);
    $display("test single done");
    slave_word <= 9'h13c;
    slave_n <= 4'h9;
    wr(`SSR_OFS_IRQC, 32'h3);
    wr(`SSR_OFS_CTRL, 32'h6f);
    poll(`SSR_OFS_STAT, 32'h4);
    chk(irq, 1'b0);
    wr(`SSR_OFS_IRQC, 32'h7);
    @(posedge aclk);
    chk(irq, 1'b1);
    rc(`SSR_OFS_STAT, 32'h5);
    rc(`SSR_OFS_DATA, 32'h3c);
    @(posedge aclk);
    chk(irq, 1'b0);
    $display("test nine bit done");
    slave_word <= 9'h05a;
    slave_n <= 4'h8;
    wr(`SSR_OFS_IRQC, 32'h6);
    wr(`SSR_OFS_IMSK, 32'h2);
    wr(`SSR_OFS_CTRL, 32'h57);
    poll(`SSR_OFS_STAT, 32'h2);
    chk(clock_pin_oe, 1'b0);
    chk(irq, 1'b1);
    rc(`SSR_OFS_STAT, 32'h6);
    rc(`SSR_OFS_ISTS, 32'h3);
    @(posedge aclk);
    chk(irq, 1'b0);
    rc(`SSR_OFS_DATA, 32'h5a);
    rc(`SSR_OFS_DATA, 32'h5a);
    wr(`SSR_OFS_CTRL, 32'h47);
    rc(`SSR_OFS_STAT, 32'h0);
    $display("test continuous done");
    for (int i = 0; i < 3; i++)
    begin
      slave_word <= tw[i];
      wr(`SSR_OFS_CTRL, 32'h4f);
      poll(`SSR_OFS_ISTS, 32'h3);
    end
    rc(`SSR_OFS_STAT, 32'h6);
    rc(`SSR_OFS_DATA, 32'h11);
    rc(`SSR_OFS_STAT, 32'h4);
    wr(`SSR_OFS_CTRL, 32'h0);
    rc(`SSR_OFS_STAT, 32'h0);
    $display("test single overrun done");
    print_verdict;
  end
endmodule
